// >>> core/hdw_dac_slave.sv
// Converter end: high-speed write receiver with byte acknowledge
// Notes on behaviour
// - Master opens with entry code at slow speed
// - Nobody acknowledges the entry code
// - Master then speeds up and repeats start
// - Own address with write flag gets acknowledged
// - One control byte follows, always acknowledged
// - Control low bit picks power-down or data
// - Data mode: acknowledge byte pairs until stop/restart
// - Word is high byte first, then low
// - Power-down mode: exactly two acknowledged bytes
// - First power-down byte: mode top, zeros below
// - Second power-down byte zero, then stop/restart
// - Pairs may stream without re-addressing
// - Repeated start returns to address stage
// - Control byte sets mode and channel
`timescale 1ns/1ps
module hdw_dac_slave
	import hdw_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	hdw_link_if.slave link,
	input wire logic addr_pin_sel_hi,
	input wire logic addr_pin_sel_lo,
	output logic hs_timing,
	output logic [1:0] chan_sel,
	output logic [1:0] load_mode,
	output logic extended_addr_hi,
	output logic extended_addr_lo,
	output logic power_down_flag,
	output logic [15:0] data_word,
	output logic word_stb,
	output logic power_down_mode_hi,
	output logic power_down_mode_lo,
	output logic pd_stb
);
	typedef struct packed {
		logic [1:0] scl_s;
		logic [1:0] sda_s;
		logic [1:0] pin_s1;
		logic [1:0] pin_s2;
		logic scl_f;
		logic sda_f;
		logic [1:0] scl_cnt;
		logic [1:0] sda_cnt;
		logic scl_d;
		logic sda_d;
		hdw_slv_e st;
		logic [3:0] bitcnt;
		logic [7:0] shreg;
		logic hs;
		logic sda_oe;
		logic [7:0] ctrl;
		logic [7:0] hi;
		logic [15:0] word;
		logic word_stb;
		logic [1:0] pd_mode;
		logic pd_stb;
	} hdw_slv_s;

	hdw_slv_s r, n;

	// Spike filter: a new level must hold for lim extra samples
	function automatic logic [2:0] filt(input logic in, input logic cur,
		input logic [1:0] cnt, input logic [1:0] lim);
		if (in == cur) begin
			filt = {cur, 2'h0};
		end else if (cnt >= lim) begin
			filt = {in, 2'h0};
		end else begin
			filt = {cur, 2'(cnt + 2'h1)};
		end
	endfunction

	// Receiver: sync, filter, find edges and conditions, then decode
	always_comb begin
		logic [1:0] lim;
		logic rise;
		logic fall;
		logic start;
		logic stop;
		logic [7:0] b;
		lim = r.hs ? SPIKE_HS_CYC : SPIKE_FS_CYC;
		n = r;
		n.word_stb = 1'b0;
		n.pd_stb = 1'b0;
		n.scl_s = {r.scl_s[0], link.scl};
		n.sda_s = {r.sda_s[0], link.sda};
		n.pin_s1 = {addr_pin_sel_hi, addr_pin_sel_lo};
		n.pin_s2 = r.pin_s1;
		{n.scl_f, n.scl_cnt} = filt(r.scl_s[1], r.scl_f, r.scl_cnt, lim);
		{n.sda_f, n.sda_cnt} = filt(r.sda_s[1], r.sda_f, r.sda_cnt, lim);
		n.scl_d = r.scl_f;
		n.sda_d = r.sda_f;
		rise = r.scl_f && !r.scl_d;
		fall = !r.scl_f && r.scl_d;
		start = r.scl_f && r.scl_d && r.sda_d && !r.sda_f;
		stop = r.scl_f && r.scl_d && !r.sda_d && r.sda_f;
		b = r.shreg;
		if (stop) begin
			// Stop ends the session and drops back to slow timing
			n.st = SLV_IDLE;
			n.hs = 1'b0;
			n.bitcnt = 4'h0;
			n.sda_oe = 1'b0;
		end else if (start) begin
			n.bitcnt = 4'h0;
			n.sda_oe = 1'b0;
			if (r.st == SLV_WAIT_SR) begin
				n.hs = 1'b1;
				n.st = SLV_ADDR;
			end else if (r.hs) begin
				n.st = SLV_ADDR;
			end else begin
				n.st = SLV_CODE;
			end
		end else if (rise && r.bitcnt < BYTE_BITS) begin
			// Sample on the rising clock, most significant bit first
			n.shreg = {r.shreg[6:0], r.sda_f};
			n.bitcnt = 4'(r.bitcnt + 4'h1);
		end else if (fall && r.bitcnt == BYTE_BITS) begin
			// Byte complete: decide on acknowledge for the ninth clock
			n.bitcnt = ACK_SLOT;
			case (r.st)
				SLV_CODE: begin
					// Never acknowledged, whatever the match
					if (b[7:3] == HS_CODE_TOP) begin
						n.st = SLV_WAIT_SR;
					end else begin
						n.st = SLV_IGNORE;
					end
				end
				SLV_ADDR: begin
					if (b == {ADDR_FIXED, r.pin_s2, WRITE_FLAG}) begin
						n.sda_oe = 1'b1;
						n.st = SLV_CTRL;
					end else begin
						n.st = SLV_IGNORE;
					end
				end
				SLV_CTRL: begin
					n.sda_oe = 1'b1;
					n.ctrl = b;
					n.st = b[CTRL_PD_BIT] ? SLV_PD_1 : SLV_DATA_HI;
				end
				SLV_DATA_HI: begin
					n.sda_oe = 1'b1;
					n.hi = b;
					n.st = SLV_DATA_LO;
				end
				SLV_DATA_LO: begin
					n.sda_oe = 1'b1;
					n.word = {r.hi, b};
					n.word_stb = 1'b1;
					n.st = SLV_DATA_HI;
				end
				SLV_PD_1: begin
					n.sda_oe = 1'b1;
					n.pd_mode = b[PD_MODE_MSB:PD_MODE_LSB];
					n.st = SLV_PD_2;
				end
				SLV_PD_2: begin
					// Second byte carries nothing; later bytes go unanswered
					n.sda_oe = 1'b1;
					n.pd_stb = 1'b1;
					n.st = SLV_IGNORE;
				end
				default: begin
					n.st = (r.st == SLV_IDLE) ? SLV_IDLE : SLV_IGNORE;
				end
			endcase
		end else if (fall && r.bitcnt == ACK_SLOT) begin
			// Release the data line once the ninth clock falls
			n.bitcnt = 4'h0;
			n.sda_oe = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			r <= '{st: SLV_IDLE, scl_s: 2'h3, sda_s: 2'h3, scl_f: 1'b1,
				sda_f: 1'b1, scl_d: 1'b1, sda_d: 1'b1, default: '0};
		end else begin
			r <= n;
		end
	end

	// Outputs other than the tied-low data output are fields of the registered state
	assign link.s_sda_o = 1'b0;
	assign link.s_sda_oe = r.sda_oe;
	assign hs_timing = r.hs;
	assign chan_sel = r.ctrl[CTRL_CH_MSB:CTRL_CH_LSB];
	assign load_mode = r.ctrl[CTRL_LD_MSB:CTRL_LD_LSB];
	assign extended_addr_hi = r.ctrl[CTRL_EX_MSB];
	assign extended_addr_lo = r.ctrl[CTRL_EX_LSB];
	assign power_down_flag = r.ctrl[CTRL_PD_BIT];
	assign data_word = r.word;
	assign word_stb = r.word_stb;
	assign power_down_mode_hi = r.pd_mode[1];
	assign power_down_mode_lo = r.pd_mode[0];
	assign pd_stb = r.pd_stb;
endmodule // hdw_dac_slave

// >>> core/hdw_link_if.sv
// Two-wire link between the bus master and the converter write port
`timescale 1ns/1ps
interface hdw_link_if;
	logic m_scl_o;
	logic m_scl_oe;
	logic m_sda_o;
	logic m_sda_oe;
	logic s_sda_o;
	logic s_sda_oe;
	logic scl;
	logic sda;

	// Open-drain wires with pull-ups: any enabled low driver wins
	assign scl = !(m_scl_oe && !m_scl_o);
	assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));

	modport master (
		output m_scl_o,
		output m_scl_oe,
		output m_sda_o,
		output m_sda_oe,
		input scl,
		input sda
	);
	modport slave (
		output s_sda_o,
		output s_sda_oe,
		input scl,
		input sda
	);
endinterface

// >>> core/hdw_master.sv
// Bus master end: sends entry code, address, control and data bytes
`timescale 1ns/1ps
module hdw_master
	import hdw_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	hdw_link_if.master link,
	input wire logic go,
	input wire logic [1:0] addr_sel,
	input wire logic [7:0] ctrl_byte,
	input wire logic [15:0] data_word,
	input wire logic more,
	output logic busy,
	output logic pair_done,
	output logic nack_seen
);
	typedef struct packed {
		logic [1:0] sda_s;
		hdw_mst_e st;
		logic [1:0] phase;
		logic [3:0] tick;
		logic [3:0] bitcnt;
		logic [2:0] sel;
		logic [7:0] shreg;
		logic hs;
		logic scl_oe;
		logic sda_oe;
		logic busy;
		logic done;
		logic nack;
		logic [1:0] addr;
		logic [7:0] ctrl;
		logic [15:0] word;
	} hdw_mst_s;

	hdw_mst_s r, n;

	// Byte for a sequence slot; power-down bytes are forced to their form
	function automatic logic [7:0] slot_byte(input logic [2:0] sel,
		input logic [1:0] addr, input logic [7:0] ctrl,
		input logic [15:0] word);
		logic pd;
		pd = ctrl[CTRL_PD_BIT];
		case (sel)
			SEL_CODE: slot_byte = {HS_CODE_TOP, HS_CODE_LOW};
			SEL_ADDR: slot_byte = {ADDR_FIXED, addr, WRITE_FLAG};
			SEL_CTRL: slot_byte = ctrl;
			SEL_HI: slot_byte = pd ? {word[15:14], PD_PAD} : word[15:8];
			default: slot_byte = pd ? PD_ZERO_BYTE : word[7:0];
		endcase
	endfunction

	// Sequencer: four quarter phases per bit from a divided core clock
	always_comb begin
		logic ack_ok;
		ack_ok = !r.sda_s[1];
		n = r;
		n.done = 1'b0;
		n.sda_s = {r.sda_s[0], link.sda};
		if (r.st == MST_IDLE) begin
			if (go) begin
				n.st = MST_START;
				n.phase = 2'h0;
				n.tick = FS_QUARTER_CYC;
				n.hs = 1'b0;
				n.busy = 1'b1;
				n.nack = 1'b0;
				n.addr = addr_sel;
				n.ctrl = ctrl_byte;
				n.word = data_word;
				n.sel = SEL_CODE;
			end
		end else if (r.tick != 4'h0) begin
			n.tick = 4'(r.tick - 4'h1);
		end else begin
			n.tick = r.hs ? HS_QUARTER_CYC : FS_QUARTER_CYC;
			n.phase = 2'(r.phase + 2'h1);
			if (r.phase == LAST_PHASE) begin
				// End of a step; the next step opens with the clock low
				n.scl_oe = 1'b1;
				case (r.st)
					MST_START: begin
						n.st = MST_BIT;
						n.bitcnt = 4'h0;
						n.shreg = slot_byte(r.sel, r.addr, r.ctrl, r.word);
					end
					MST_RSTART: begin
						n.st = MST_BIT;
						n.bitcnt = 4'h0;
						n.sel = SEL_ADDR;
						n.shreg = slot_byte(SEL_ADDR, r.addr, r.ctrl, r.word);
					end
					MST_BIT: begin
						if (r.bitcnt != BYTE_BITS) begin
							n.bitcnt = 4'(r.bitcnt + 4'h1);
							n.shreg = {r.shreg[6:0], 1'b0};
						end else if (r.sel == SEL_CODE) begin
							// Entry code is never acknowledged
							n.st = MST_RSTART;
							n.hs = 1'b1;
							n.tick = HS_QUARTER_CYC;
						end else if (!ack_ok) begin
							n.st = MST_STOP;
							n.nack = 1'b1;
						end else if (r.sel == SEL_LO) begin
							n.done = 1'b1;
							if (more && !r.ctrl[CTRL_PD_BIT]) begin
								n.word = data_word;
								n.sel = SEL_HI;
								n.bitcnt = 4'h0;
								n.shreg = slot_byte(SEL_HI, r.addr, r.ctrl,
									data_word);
							end else begin
								n.st = MST_STOP;
							end
						end else begin
							n.sel = 3'(r.sel + 3'h1);
							n.bitcnt = 4'h0;
							n.shreg = slot_byte(3'(r.sel + 3'h1), r.addr,
								r.ctrl, r.word);
						end
					end
					default: begin
						n.st = MST_IDLE;
						n.busy = 1'b0;
						n.hs = 1'b0;
						n.scl_oe = 1'b0;
					end
				endcase
			end else begin
				// Phases 0..2; bit data moves while the clock is low, start and stop edges while it is high
				case (r.st)
					MST_START: begin
						if (r.phase == 2'h0) n.sda_oe = 1'b1;
						if (r.phase == 2'h2) n.scl_oe = 1'b1;
					end
					MST_BIT: begin
						if (r.phase == 2'h0) begin
							n.sda_oe = (r.bitcnt == BYTE_BITS) ? 1'b0 :
								!r.shreg[7];
						end
						if (r.phase == 2'h1) n.scl_oe = 1'b0;
					end
					MST_RSTART: begin
						if (r.phase == 2'h0) n.sda_oe = 1'b0;
						if (r.phase == 2'h1) n.scl_oe = 1'b0;
						if (r.phase == 2'h2) n.sda_oe = 1'b1;
					end
					default: begin
						if (r.phase == 2'h0) n.sda_oe = 1'b1;
						if (r.phase == 2'h1) n.scl_oe = 1'b0;
						if (r.phase == 2'h2) n.sda_oe = 1'b0;
					end
				endcase
			end
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			r <= '{st: MST_IDLE, default: '0};
		end else begin
			r <= n;
		end
	end

	// Open-drain drivers only ever pull low
	assign link.m_scl_o = 1'b0;
	assign link.m_sda_o = 1'b0;
	assign link.m_scl_oe = r.scl_oe;
	assign link.m_sda_oe = r.sda_oe;
	assign busy = r.busy;
	assign pair_done = r.done;
	assign nack_seen = r.nack;
endmodule // hdw_master

// >>> core/hdw_pkg.sv
// Shared constants and types for the high-speed write link, both ends
package hdw_pkg;
	// Byte framing on the link
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] ACK_SLOT = 4'h9;
	// Address byte: fixed upper five bits, two pin bits, write flag
	localparam logic [4:0] ADDR_FIXED = 5'h13;
	localparam logic WRITE_FLAG = 1'h0;
	// Entry code: upper five bits, low three bits are don't care
	localparam logic [4:0] HS_CODE_TOP = 5'h01;
	localparam logic [2:0] HS_CODE_LOW = 3'h0;
	// Control byte field positions
	localparam int CTRL_PD_BIT = 0;
	localparam int CTRL_CH_LSB = 1;
	localparam int CTRL_CH_MSB = 2;
	localparam int CTRL_LD_LSB = 4;
	localparam int CTRL_LD_MSB = 5;
	localparam int CTRL_EX_LSB = 6;
	localparam int CTRL_EX_MSB = 7;
	// Power-down byte: mode in the top two bits, rest zero
	localparam int PD_MODE_LSB = 6;
	localparam int PD_MODE_MSB = 7;
	localparam logic [5:0] PD_PAD = 6'h00;
	localparam logic [7:0] PD_ZERO_BYTE = 8'h00;
	// Timing, core clock 10 MHz
	localparam int CLK_PERIOD_NS = 100;
	localparam int T_SPIKE_FS_NS = 50;
	localparam int T_FS_QUARTER_NS = 800;
	localparam int T_HS_QUARTER_NS = 400;
	localparam logic [1:0] SPIKE_FS_CYC =
		2'((T_SPIKE_FS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [1:0] SPIKE_HS_CYC = 2'h0;
	localparam logic [3:0] FS_QUARTER_CYC =
		4'((T_FS_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] HS_QUARTER_CYC =
		4'((T_HS_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [1:0] LAST_PHASE = 2'h3;
	// Master byte sequence slots
	localparam logic [2:0] SEL_CODE = 3'h0;
	localparam logic [2:0] SEL_ADDR = 3'h1;
	localparam logic [2:0] SEL_CTRL = 3'h2;
	localparam logic [2:0] SEL_HI = 3'h3;
	localparam logic [2:0] SEL_LO = 3'h4;

	typedef enum logic [9:0] {
		SLV_IDLE = 10'h001,
		SLV_CODE = 10'h002,
		SLV_WAIT_SR = 10'h004,
		SLV_ADDR = 10'h008,
		SLV_CTRL = 10'h010,
		SLV_DATA_HI = 10'h020,
		SLV_DATA_LO = 10'h040,
		SLV_PD_1 = 10'h080,
		SLV_PD_2 = 10'h100,
		SLV_IGNORE = 10'h200
	} hdw_slv_e;

	typedef enum logic [4:0] {
		MST_IDLE = 5'h01,
		MST_START = 5'h02,
		MST_BIT = 5'h04,
		MST_RSTART = 5'h08,
		MST_STOP = 5'h10
	} hdw_mst_e;
endpackage

// >>> verification/hdw_link_props.sv
// Link checker: timing relations on the shared two-wire lines
`timescale 1ns/1ps
module hdw_link_props
	import hdw_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic m_scl_o,
	input wire logic m_scl_oe,
	input wire logic m_sda_o,
	input wire logic m_sda_oe,
	input wire logic s_sda_o,
	input wire logic s_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	logic [4:0] hi_cnt_ff;
	logic [4:0] oe_cnt_ff;
	logic slow_ff;

	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	// Counters saturate so that a long idle bus never wraps
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			hi_cnt_ff <= 5'h00;
			oe_cnt_ff <= 5'h00;
			slow_ff <= 1'b0;
		end else begin
			hi_cnt_ff <= !scl ? 5'h00 : hi_cnt_ff + 5'(hi_cnt_ff != 5'h1f);
			oe_cnt_ff <= !s_sda_oe ? 5'h00 : oe_cnt_ff + 5'(oe_cnt_ff != 5'h1f);
			if (!scl && hi_cnt_ff != 5'h00) begin
				slow_ff <= hi_cnt_ff > 5'(3 * HS_QUARTER_CYC); // Last bit slow
			end
		end
	end

	wire_low_a: assert property (!m_scl_o && !m_sda_o && !s_sda_o)
		else $error("open-drain data output not low");
	ack_setup_a: assert property ($rose(s_sda_oe) |-> !scl)
		else $error("ack raised while clock high");
	code_nack_a: assert property ($rose(s_sda_oe) |-> !slow_ff)
		else $error("ack given at slow bus speed");
	ack_release_a: assert property ($fell(s_sda_oe) |-> !scl)
		else $error("ack dropped while clock high");
	ack_stands_a: assert property (
		s_sda_oe && $rose(scl) |-> s_sda_oe [*6])
		else $error("ack not held through clock high");
	ack_len_a: assert property (oe_cnt_ff < 5'h18)
		else $error("ack held beyond one bit");
	master_yield_a: assert property (s_sda_oe && scl |-> !m_sda_oe)
		else $error("master drives data in ack slot");
	hs_width_a: assert property (
		$fell(scl) |-> hi_cnt_ff >= 5'(2 * HS_QUARTER_CYC))
		else $error("clock high time too short");
endmodule // hdw_link_props

// >>> verification/tb_hs_mode_dac_write_slave.sv
// Testbench: master and converter ends joined over the two-wire link
`timescale 1ns/1ps
module tb_hs_mode_dac_write_slave
	import hdw_pkg::*;
;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic go = 1'b0;
	logic [1:0] addr_sel = 2'h0;
	logic [7:0] ctrl_byte = 8'h00;
	logic [15:0] m_word = 16'h0000;
	logic more = 1'b0;
	logic [1:0] pins = 2'h0;
	logic busy, pair_done, nack_seen, hs_timing, word_stb, pd_stb;
	logic [1:0] chan_sel, load_mode;
	logic extended_addr_hi, extended_addr_lo, power_down_flag;
	logic power_down_mode_hi, power_down_mode_lo;
	logic [15:0] s_word;
	logic hs_seen;
	int miscompares = 0;
	int compares = 0;
	int words, pds, pairs;

	// Free-running core clock
	initial begin
		forever #50 core_clk = ~core_clk;
	end

	// Both ends face each other across one link
	hdw_link_if link();
	hdw_master hdw_master_i (.core_clk(core_clk), .arst_n(arst_n),
		.link(link), .go(go), .addr_sel(addr_sel), .ctrl_byte(ctrl_byte),
		.data_word(m_word), .more(more), .busy(busy),
		.pair_done(pair_done), .nack_seen(nack_seen));
	hdw_dac_slave hdw_dac_slave_i (.core_clk(core_clk), .arst_n(arst_n),
		.link(link), .addr_pin_sel_hi(pins[1]), .addr_pin_sel_lo(pins[0]),
		.hs_timing(hs_timing), .chan_sel(chan_sel), .load_mode(load_mode),
		.extended_addr_hi(extended_addr_hi),
		.extended_addr_lo(extended_addr_lo),
		.power_down_flag(power_down_flag), .data_word(s_word),
		.word_stb(word_stb), .power_down_mode_hi(power_down_mode_hi),
		.power_down_mode_lo(power_down_mode_lo), .pd_stb(pd_stb));
	hdw_link_props hdw_link_props_i (.core_clk(core_clk), .arst_n(arst_n),
		.m_scl_o(link.m_scl_o), .m_scl_oe(link.m_scl_oe),
		.m_sda_o(link.m_sda_o), .m_sda_oe(link.m_sda_oe),
		.s_sda_o(link.s_sda_o), .s_sda_oe(link.s_sda_oe),
		.scl(link.scl), .sda(link.sda));

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// One whole write; pins settle through the sync chain before go
	task automatic run(input logic [1:0] p, input logic [1:0] a,
		input logic [7:0] c, input logic [15:0] w, input int n);
		int left;
		int t;
		left = n;
		t = 0;
		words = 0;
		pds = 0;
		pairs = 0;
		hs_seen = 1'b0;
		@(posedge core_clk);
		pins <= p;
		repeat (4) @(posedge core_clk);
		addr_sel <= a;
		ctrl_byte <= c;
		m_word <= w;
		more <= (n > 1);
		go <= 1'b1;
		@(posedge core_clk);
		go <= 1'b0;
		// A streamed second word must differ from the first one
		m_word <= ~w;
		// Outputs are looked at on the falling edge, clear of updates
		do begin
			@(posedge core_clk);
			if (left <= 1) begin
				more <= 1'b0;
			end
			@(negedge core_clk);
			t++;
			if (word_stb === 1'b1 || pd_stb === 1'b1) begin
				hs_seen = hs_seen | hs_timing;
			end
			words += int'(word_stb === 1'b1);
			pds += int'(pd_stb === 1'b1);
			pairs += int'(pair_done === 1'b1);
			left -= int'(pair_done === 1'b1);
		end while (busy !== 1'b0 && t < 9000);
		chk(16'(busy), 16'h0000);
		// Let the stop reach the slave through its synchroniser
		repeat (10) @(negedge core_clk);
		chk(16'(hs_timing), 16'h0000);
	endtask

	// Outputs while reset is held and just after its release
	task automatic t_reset();
		chk(16'({busy, nack_seen, hs_timing, word_stb, pd_stb}), 16'h0000);
		chk(s_word, 16'h0000);
		@(posedge core_clk);
		arst_n <= 1'b1;
		// Both lines must stay released, so no false start follows reset
		@(negedge core_clk);
		chk(16'({busy, hs_timing, link.s_sda_oe, link.scl, link.sda}),
			16'h0003);
	endtask

	// Every pin setting and channel; the first run streams two words
	task automatic t_data();
		logic [7:0] c;
		logic [15:0] w;
		for (int ch = 0; ch < 4; ch++) begin
			c = {2'(ch), 2'(3 - ch), 1'b0, 2'(ch), 1'b0};
			w = 16'ha53c ^ 16'(ch * 16'h1111);
			run(2'(ch), 2'(ch), c, w, ch == 0 ? 2 : 1);
			chk(16'(words), ch == 0 ? 16'h0002 : 16'h0001);
			chk(16'(pairs), ch == 0 ? 16'h0002 : 16'h0001);
			chk(s_word, ch == 0 ? ~w : w);
			chk(16'({chan_sel, load_mode, power_down_flag}),
				16'({2'(ch), 2'(3 - ch), 1'b0}));
			chk(16'({extended_addr_hi, extended_addr_lo}), 16'(ch));
			chk(16'(pds), 16'h0000);
			chk(16'(nack_seen), 16'h0000);
			chk(16'(hs_seen), 16'h0001);
		end
	endtask

	// Address pins differ from the sent address: nothing is taken
	task automatic t_wrong();
		run(2'h1, 2'h2, 8'h02, 16'h1234, 1);
		chk(16'(nack_seen), 16'h0001);
		chk(16'(words), 16'h0000);
		chk(16'(pairs), 16'h0000);
		chk(16'(chan_sel), 16'h0003);
	endtask

	// All four power-down modes, two bytes each
	task automatic t_pd();
		for (int m = 0; m < 4; m++) begin
			run(2'h0, 2'h0, {2'(m), 2'h0, 1'b0, 2'(m), 1'b1}, {2'(m), 14'h0}, 1);
			chk(16'(pds), 16'h0001);
			chk(16'(pairs), 16'h0001);
			chk(16'(words), 16'h0000);
			chk(16'({power_down_mode_hi, power_down_mode_lo}), 16'(m));
			chk(16'(power_down_flag), 16'h0001);
			chk(16'(nack_seen), 16'h0000);
		end
	endtask

	// Reset in mid-frame: both ends fall idle, then a write goes through
	task automatic t_abort();
		@(posedge core_clk);
		addr_sel <= 2'h0;
		ctrl_byte <= 8'h00;
		more <= 1'b0;
		go <= 1'b1;
		@(posedge core_clk);
		go <= 1'b0;
		// Far enough to be inside the fast address byte
		repeat (500) @(posedge core_clk);
		@(negedge core_clk);
		chk(16'({busy, hs_timing}), 16'h0003);
		@(posedge core_clk);
		arst_n <= 1'b0;
		@(negedge core_clk);
		chk(16'({busy, hs_timing, link.s_sda_oe, link.scl, link.sda}),
			16'h0003);
		@(posedge core_clk);
		arst_n <= 1'b1;
		run(2'h0, 2'h0, 8'h00, 16'h5aa5, 1);
		chk(16'(words), 16'h0001);
		chk(s_word, 16'h5aa5);
	endtask

	// Main sequence
	initial begin
		repeat (7) @(posedge core_clk);
		@(negedge core_clk);
		t_reset();
		t_data();
		t_wrong();
		t_pd();
		t_abort();
		finish_test();
	end

	// Watchdog: about three times the expected run length
	initial begin
		#4000000;
		miscompares++;
		finish_test();
	end
endmodule // tb_hs_mode_dac_write_slave
